// ---- design/pc_sequencer.sv ----
// Purpose: Next program counter and push/pop decision for one core step
// Assumes: pc holds the address of the step being completed
// Notes:   Pure combinational

`timescale 1ns/1ps

module pc_sequencer (
  // Step
  input  wire pc_stack_pkg::step_op_e            op,
  input  wire logic [pc_stack_pkg::PC_W-1:0]     pc,
  input  wire logic [pc_stack_pkg::CALL_W-1:0]   call_target,
  input  wire logic [pc_stack_pkg::REL_W-1:0]    rel_offset,
  input  wire logic [pc_stack_pkg::BYTE_W-1:0]   w_value,
  input  wire logic [pc_stack_pkg::BYTE_W-1:0]   low_value,
  input  wire logic [pc_stack_pkg::LATCH_W-1:0]  pc_high_latch,
  input  wire logic [pc_stack_pkg::PC_W-1:0]     tos,
  input  wire logic [pc_stack_pkg::PC_W-1:0]     vector,
  // Result
  output logic [pc_stack_pkg::PC_W-1:0]          pc_next,
  output logic                                   push,
  output logic                                   pop,
  output logic [pc_stack_pkg::PC_W-1:0]          push_data
);
  import pc_stack_pkg::*;

  logic [PC_W-1:0] inc;

  always_comb begin
    inc       = PC_W'(pc + 1'h1);
    pc_next   = inc;
    push      = 1'h0;
    pop       = 1'h0;
    push_data = inc;
    unique case (op)
      OP_NEXT: begin
      end
      OP_LOW_WRITE: begin
        pc_next = {pc_high_latch, low_value};
      end
      OP_CALL: begin
        pc_next = {pc_high_latch[LATCH_W-1:PAGE_LSB], call_target};
        push    = 1'h1;
      end
      OP_CALL_WORK: begin
        pc_next = {pc_high_latch, w_value};
        push    = 1'h1;
      end
      OP_BRANCH_WORK: begin
        pc_next = PC_W'(inc + {{(PC_W-BYTE_W){1'h0}}, w_value});
      end
      OP_BRANCH_REL: begin
        pc_next = PC_W'(inc + {{(PC_W-REL_W){rel_offset[REL_W-1]}},
                               rel_offset});
      end
      OP_RETURN: begin
        pc_next = tos;
        pop     = 1'h1;
      end
      OP_IRQ: begin
        pc_next   = vector;
        push      = 1'h1;
        push_data = pc;
      end
    endcase
  end

endmodule // pc_sequencer

// ---- design/pc_stack_top.sv ----
// Purpose: Program counter sequencing and hardware return-address stack
// Assumes: Decoder offers one step per cycle while step_valid is high
// Notes:   AXI4-Lite slave reaches level index, top of stack and flags
//
// Behaviour
// - Program counter is fifteen bits; low byte is the pc_low_byte value.
// - Upper seven counter bits load whole from pc_high_latch only on pc_low_byte writes and calls via working.
// - Every reset clears the whole program counter.
// - Writing pc_low_byte loads low byte and copies latch into upper bits.
// - Call loads eleven operand bits, upper four bits from latch.
// - Call via working loads low byte from W, upper bits from latch.
// - Branch by working jumps to incremented counter plus unsigned W.
// - Relative branch adds sign-extended nine-bit offset to counter plus one.
// - Sixteen fifteen-bit stack entries, separate from program and data.
// - Calls and interrupts push; returns pop; latch never touched.
// - Without fault reset the stack wraps and overwrites oldest entries.
// - Overflow and underflow flags set whether or not reset is enabled.
// - With fault reset enabled, a fault resets and records its flag.
// - Software picks an entry by index and reads or writes it.
// - Level index is five bits to show overflow and underflow.
// - Push increments then stores; pop reads then decrements.
// - Level index points at the entry in use, except IDX_EMPTY (1f), which marks an empty stack.

`timescale 1ns/1ps

module pc_stack_top #(
  parameter logic [pc_stack_pkg::PC_W-1:0] IRQ_VECTOR =
    pc_stack_pkg::IRQ_VECTOR_DEF
) (
  // Clock, reset, enable
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  input  wire logic                               ce,
  // Core step
  input  wire logic                               step_valid,
  input  wire pc_stack_pkg::step_op_e             step_op,
  input  wire logic [pc_stack_pkg::CALL_W-1:0]    call_target,
  input  wire logic [pc_stack_pkg::REL_W-1:0]     rel_offset,
  input  wire logic [pc_stack_pkg::BYTE_W-1:0]    w_value,
  input  wire logic [pc_stack_pkg::BYTE_W-1:0]    low_value,
  input  wire logic [pc_stack_pkg::LATCH_W-1:0]   pc_high_latch,
  input  wire logic                               stack_fault_reset_enable,
  // Core results
  output logic [pc_stack_pkg::PC_W-1:0]           pc,
  output logic                                    stack_fault_reset,
  output logic                                    irq,
  // AXI4-Lite write
  input  wire logic                               awvalid,
  output logic                                    awready,
  input  wire logic [pc_stack_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                               wvalid,
  output logic                                    wready,
  input  wire logic [pc_stack_pkg::DATA_W-1:0]    wdata,
  input  wire logic [pc_stack_pkg::STRB_W-1:0]    wstrb,
  output logic                                    bvalid,
  input  wire logic                               bready,
  output logic [1:0]                              bresp,
  // AXI4-Lite read
  input  wire logic                               arvalid,
  output logic                                    arready,
  input  wire logic [pc_stack_pkg::ADDR_W-1:0]    araddr,
  output logic                                    rvalid,
  input  wire logic                               rready,
  output logic [pc_stack_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                              rresp
);
  import pc_stack_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [PC_W-1:0]   pc;
    logic [IDX_W-1:0]  idx;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] irq_en;
    logic              irq;
    logic              fault_rst;
    logic              aw_rdy;
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_rdy;
    logic              w_have;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              ar_rdy;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } state_s;

  localparam state_s ST_RESET = '{
    pc: PC_RESET, idx: IDX_EMPTY, aw_rdy: 1'h1, w_rdy: 1'h1,
    ar_rdy: 1'h1, default: '0};

  state_s           st_reg;
  state_s           st_next;
  logic [PC_W-1:0]  seq_pc_next;
  logic             seq_push;
  logic             seq_pop;
  logic [PC_W-1:0]  seq_push_data;
  logic             push;
  logic             pop;
  logic             ovf_evt;
  logic             unf_evt;
  logic             fault_cut;
  logic             wr_go;
  logic             wr_lane;
  logic             sw_tos_we;
  logic [PC_W-1:0]  sw_tos_data;
  logic [IDX_W-1:0] idx_inc;

  stack_if sif ();

  return_stack u_stack (
    .aclk (aclk),
    .sif  (sif)
  );

  pc_sequencer u_seq (
    .op            (step_op),
    .pc            (st_reg.pc),
    .call_target   (call_target),
    .rel_offset    (rel_offset),
    .w_value       (w_value),
    .low_value     (low_value),
    .pc_high_latch (pc_high_latch),
    .tos           (sif.rdata),
    .vector        (IRQ_VECTOR),
    .pc_next       (seq_pc_next),
    .push          (seq_push),
    .pop           (seq_pop),
    .push_data     (seq_push_data)
  );

  // ==========================================================
  // Next state
  always_comb begin
    st_next     = st_reg;
    sw_tos_we   = 1'h0;
    sw_tos_data = sif.rdata;
    idx_inc     = IDX_W'(st_reg.idx + 1'h1);
    st_next.fault_rst = 1'h0;

    // Read channel
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'h0;
    end
    if (st_reg.ar_rdy && arvalid) begin
      st_next.rvalid = 1'h1;
      st_next.rresp  = RESP_OKAY;
      st_next.rdata  = '0;
      case (araddr[ADDR_W-1:REG_LSB])
        IDX_LEVEL:  st_next.rdata[IDX_W-1:0] = st_reg.idx;
        IDX_TOS_LOW:  st_next.rdata[BYTE_W-1:0] =
                      sif.rdata[BYTE_W-1:0];
        IDX_TOS_HIGH: st_next.rdata[LATCH_W-1:0] =
                      sif.rdata[PC_W-1:BYTE_W];
        IDX_STATUS: st_next.rdata[FLAG_W-1:0] = st_reg.flags;
        IDX_ENABLE: st_next.rdata[FLAG_W-1:0] = st_reg.irq_en;
        IDX_CLEAR:  st_next.rdata = '0;
        default:    st_next.rresp = RESP_SLVERR;
      endcase
    end
    st_next.ar_rdy = !st_next.rvalid;

    // Write channels
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'h0;
    end
    if (st_reg.aw_rdy && awvalid) begin
      st_next.aw_have = 1'h1;
      st_next.aw_addr = awaddr;
    end
    if (st_reg.w_rdy && wvalid) begin
      st_next.w_have = 1'h1;
      st_next.wdata  = wdata;
      st_next.wstrb  = wstrb;
    end
    wr_go   = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    wr_lane = wr_go && st_reg.wstrb[0];
    if (wr_go) begin
      st_next.aw_have = 1'h0;
      st_next.w_have  = 1'h0;
      st_next.bvalid  = 1'h1;
      st_next.bresp   = RESP_OKAY;
      case (st_reg.aw_addr[ADDR_W-1:REG_LSB])
        IDX_LEVEL: begin
          if (wr_lane) begin
            st_next.idx = st_reg.wdata[IDX_W-1:0];
          end
        end
        IDX_TOS_LOW: begin
          sw_tos_we = wr_lane;
          sw_tos_data[BYTE_W-1:0] = st_reg.wdata[BYTE_W-1:0];
        end
        IDX_TOS_HIGH: begin
          sw_tos_we = wr_lane;
          sw_tos_data[PC_W-1:BYTE_W] = st_reg.wdata[LATCH_W-1:0];
        end
        IDX_STATUS: begin
        end
        IDX_CLEAR: begin
          if (wr_lane) begin
            st_next.flags = st_reg.flags & ~st_reg.wdata[FLAG_W-1:0];
          end
        end
        IDX_ENABLE: begin
          if (wr_lane) begin
            st_next.irq_en = st_reg.wdata[FLAG_W-1:0];
          end
        end
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    st_next.aw_rdy = !st_next.aw_have && !st_next.bvalid;
    st_next.w_rdy  = !st_next.w_have && !st_next.bvalid;

    // Core step; a push, pop or fault reset overrides a software index write in the same cycle
    push    = step_valid && seq_push;
    pop     = step_valid && seq_pop;
    ovf_evt = push && (st_reg.idx >= IDX_LAST) &&
              (st_reg.idx != IDX_EMPTY);
    unf_evt = pop && (st_reg.idx == IDX_EMPTY);
    fault_cut = (ovf_evt || unf_evt) && stack_fault_reset_enable;
    if (fault_cut) begin
      st_next.pc        = PC_RESET;
      st_next.idx       = IDX_EMPTY;
      st_next.fault_rst = 1'h1;
    end else if (step_valid) begin
      st_next.pc = seq_pc_next;
      if (push) begin
        st_next.idx = idx_inc;
      end else if (pop) begin
        st_next.idx = IDX_W'(st_reg.idx - 1'h1);
      end
    end
    // Hardware set wins over a clear in the same cycle
    st_next.flags[OVF_BIT] = st_next.flags[OVF_BIT] | ovf_evt;
    st_next.flags[UNF_BIT] = st_next.flags[UNF_BIT] | unf_evt;
    st_next.irq = |(st_next.flags & st_next.irq_en);

    // Array port: a push has priority over a software entry write
    sif.raddr = st_reg.idx[ENT_W-1:0];
    sif.we    = ce && ((push && !fault_cut) || sw_tos_we);
    sif.waddr = (push && !fault_cut) ? idx_inc[ENT_W-1:0] :
                                       st_reg.idx[ENT_W-1:0];
    sif.wdata = (push && !fault_cut) ? seq_push_data : sw_tos_data;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign pc                = st_reg.pc;
  assign stack_fault_reset = st_reg.fault_rst;
  assign irq               = st_reg.irq;
  assign awready           = st_reg.aw_rdy;
  assign wready            = st_reg.w_rdy;
  assign bvalid            = st_reg.bvalid;
  assign bresp             = st_reg.bresp;
  assign arready           = st_reg.ar_rdy;
  assign rvalid            = st_reg.rvalid;
  assign rdata             = st_reg.rdata;
  assign rresp             = st_reg.rresp;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic fire;
  assign fire = ce && step_valid && !fault_cut;

  property p_low_load;
    fire && step_op == OP_LOW_WRITE |=>
      pc == {$past(pc_high_latch), $past(low_value)};
  endproperty
  a_low_load: assert property (p_low_load)
    else $error("pc low byte write did not load latch and byte");

  property p_call;
    fire && step_op == OP_CALL |=>
      pc == {$past(pc_high_latch[LATCH_W-1:PAGE_LSB]), $past(call_target)};
  endproperty
  a_call: assert property (p_call)
    else $error("call target wrong");

  property p_call_work;
    fire && step_op == OP_CALL_WORK |=>
      pc == {$past(pc_high_latch), $past(w_value)};
  endproperty
  a_call_work: assert property (p_call_work)
    else $error("call via working target wrong");

  property p_branch_work;
    fire && step_op == OP_BRANCH_WORK |=>
      pc == PC_W'($past(pc) + 1'h1 + $past(w_value));
  endproperty
  a_branch_work: assert property (p_branch_work)
    else $error("branch by working target wrong");

  property p_branch_rel;
    fire && step_op == OP_BRANCH_REL |=> pc == PC_W'($past(pc) + 1'h1 +
      {{(PC_W-REL_W){$past(rel_offset[REL_W-1])}}, $past(rel_offset)});
  endproperty
  a_branch_rel: assert property (p_branch_rel)
    else $error("relative branch target wrong");

  property p_pop;
    fire && step_op == OP_RETURN |=>
      pc == $past(sif.rdata) && st_reg.idx == IDX_W'($past(st_reg.idx) - 1);
  endproperty
  a_pop: assert property (p_pop)
    else $error("return did not restore top entry");

  property p_push_then_read;
    fire && seq_push |=>
      sif.rdata == $past(seq_push_data) &&
      st_reg.idx == $past(idx_inc);
  endproperty
  a_push_then_read: assert property (p_push_then_read)
    else $error("pushed address not found at new level");

  property p_wrap;
    ce && step_valid && seq_push && st_reg.idx == IDX_LAST &&
      !stack_fault_reset_enable |=>
      st_reg.idx == IDX_W'(IDX_LAST + 1) && st_reg.flags[OVF_BIT];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("overflow without reset did not wrap and flag");

  property p_unf;
    ce && step_valid && seq_pop && st_reg.idx == IDX_EMPTY |=>
      st_reg.flags[UNF_BIT];
  endproperty
  a_unf: assert property (p_unf)
    else $error("underflow flag not set");

  property p_fault_reset;
    ce && fault_cut |=> stack_fault_reset && pc == PC_RESET &&
      st_reg.idx == IDX_EMPTY ##1 (!$past(ce) || $past(fault_cut) ||
        !stack_fault_reset);
  endproperty
  a_fault_reset: assert property (p_fault_reset)
    else $error("stack fault reset not issued for one step");

  property p_write_answer;
    ce && wr_go |=> bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response missing");

  c_overflow: cover property (ce && ovf_evt);
  c_underflow: cover property (ce && unf_evt);
  c_fault: cover property (ce && fault_cut);
  c_tos_write: cover property (ce && sw_tos_we);

endmodule // pc_stack_top

// ---- design/return_stack.sv ----
// Purpose: Sixteen-entry return address array, apart from all memories
// Assumes: Write enable is qualified by the caller
// Notes:   Entries are not reset; contents are unknown until written

`timescale 1ns/1ps

module return_stack (
  // Clock
  input wire logic aclk,
  // Array port
  stack_if.mem     sif
);
  import pc_stack_pkg::*;

  logic [PC_W-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (sif.we) begin
      mem[sif.waddr] <= sif.wdata;
    end
  end

  assign sif.rdata = mem[sif.raddr];

endmodule // return_stack

// ---- pkg/pc_stack_pkg.sv ----
// Purpose: Shared constants and types for the program counter and stack
// Assumes: 32-bit AXI4-Lite register bus, one core step per enabled cycle
// Notes:   Register offsets are word indices; byte address is index * 4

package pc_stack_pkg;

  // ==========================================================
  // Program counter and stack geometry
  localparam int PC_W    = 15;
  localparam int BYTE_W  = 8;
  localparam int LATCH_W = 7;
  localparam int CALL_W  = 11;
  localparam int REL_W   = 9;
  localparam int DEPTH   = 16;
  localparam int ENT_W   = 4;
  localparam int IDX_W   = 5;
  localparam int PAGE_LSB = CALL_W - BYTE_W;

  localparam logic [IDX_W-1:0] IDX_EMPTY = 5'h1f;
  localparam logic [IDX_W-1:0] IDX_LAST  = 5'h0f;
  localparam logic [PC_W-1:0]  PC_RESET  = 15'h0000;
  // Interrupt vector default is arbitrary
  localparam logic [PC_W-1:0]  IRQ_VECTOR_DEF = 15'h0004;

  // ==========================================================
  // Register bus
  localparam int DATA_W  = 32;
  localparam int STRB_W  = 4;
  localparam int ADDR_W  = 14;
  localparam int REG_LSB = 2;
  localparam int REGI_W  = ADDR_W - REG_LSB;

  localparam logic [REGI_W-1:0] IDX_LEVEL    = 12'hfed;
  localparam logic [REGI_W-1:0] IDX_TOS_LOW  = 12'hfee;
  localparam logic [REGI_W-1:0] IDX_TOS_HIGH = 12'hfef;
  localparam logic [REGI_W-1:0] IDX_STATUS   = 12'hff0;
  localparam logic [REGI_W-1:0] IDX_CLEAR    = 12'hff1;
  localparam logic [REGI_W-1:0] IDX_ENABLE   = 12'hff2;

  localparam int FLAG_W  = 2;
  localparam int OVF_BIT = 0;
  localparam int UNF_BIT = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Core step kinds
  typedef enum logic [2:0] {
    OP_NEXT        = 3'h0,
    OP_LOW_WRITE   = 3'h1,
    OP_CALL        = 3'h2,
    OP_CALL_WORK   = 3'h3,
    OP_BRANCH_WORK = 3'h4,
    OP_BRANCH_REL  = 3'h5,
    OP_RETURN      = 3'h6,
    OP_IRQ         = 3'h7
  } step_op_e;

endpackage

// ---- pkg/stack_if.sv ----
// Purpose: Port bundle between the controller and the return stack array
// Assumes: One write port, one asynchronous read port
// Notes:   Write enable already carries the clock enable

`timescale 1ns/1ps

interface stack_if;
  logic                          we;
  logic [pc_stack_pkg::ENT_W-1:0] waddr;
  logic [pc_stack_pkg::PC_W-1:0]  wdata;
  logic [pc_stack_pkg::ENT_W-1:0] raddr;
  logic [pc_stack_pkg::PC_W-1:0]  rdata;

  modport ctrl (output we, waddr, wdata, raddr, input rdata);
  modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

// ---- tb/core_step_model.sv ----
// Purpose: Core decoder stand-in that offers one step at a time
// Assumes: Steps launch right after a rising edge and stand one cycle
// Notes:   Operands are fresh every step even where the op ignores them

`timescale 1ns/1ps

module core_step_model (
  // Clock
  input  wire logic                             aclk,
  // Step
  output logic                                  step_valid,
  output pc_stack_pkg::step_op_e                step_op,
  output logic [pc_stack_pkg::CALL_W-1:0]       call_target,
  output logic [pc_stack_pkg::REL_W-1:0]        rel_offset,
  output logic [pc_stack_pkg::BYTE_W-1:0]       w_value,
  output logic [pc_stack_pkg::BYTE_W-1:0]       low_value,
  output logic [pc_stack_pkg::LATCH_W-1:0]      pc_high_latch
);
  import pc_stack_pkg::*;

  initial begin
    step_valid    = 1'b0;
    step_op       = OP_NEXT;
    call_target   = 11'h000;
    rel_offset    = 9'h000;
    w_value       = 8'h00;
    low_value     = 8'h00;
    pc_high_latch = 7'h00;
  end

  task automatic run(input step_op_e o, input logic [10:0] t,
                     input logic [8:0] b, input logic [7:0] w,
                     input logic [7:0] p, input logic [6:0] l);
    @(posedge aclk);
    step_op       <= o;
    call_target   <= t;
    rel_offset    <= b;
    w_value       <= w;
    low_value     <= p;
    pc_high_latch <= l;
    step_valid    <= 1'b1;
    @(posedge aclk);
    step_valid    <= 1'b0;
  endtask
endmodule // core_step_model

// ---- tb/pc_stack_top_test.sv ----
// Purpose: Self-checking bench for the program counter and return stack
// Assumes: One bus access at a time; clock enable dropped once
// Notes:   Expected counter, level and flags come from a bench model

`timescale 1ns/1ps

module pc_stack_top_test;
  import pc_stack_pkg::*;

  // ==========================================================
  // Signals and model state
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, fre = 1'b0;
  logic step_valid, fault, irq;
  step_op_e step_op;
  logic [10:0] call_target;
  logic [8:0] rel_offset;
  logic [7:0] w_value, low_value;
  logic [6:0] pc_high_latch;
  logic [14:0] pc;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
  logic [31:0] wdata = 32'h0, rdata, rd, r;
  logic [3:0] strb = 4'hf;
  logic [1:0] bresp, rresp, rs, bs;
  integer err_count = 0, checked = 0, seed = 31;
  logic [14:0] m_pc = 15'h0000, m_stk [16];
  logic [4:0] m_lvl = 5'h1f;
  logic [1:0] m_flg = 2'h0;

  always #4 aclk = ~aclk;

  pc_stack_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .step_valid(step_valid), .step_op(step_op),
    .call_target(call_target), .rel_offset(rel_offset),
    .w_value(w_value), .low_value(low_value),
    .pc_high_latch(pc_high_latch), .stack_fault_reset_enable(fre),
    .pc(pc), .stack_fault_reset(fault), .irq(irq),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(strb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  core_step_model core (.aclk(aclk), .step_valid(step_valid),
    .step_op(step_op), .call_target(call_target),
    .rel_offset(rel_offset), .w_value(w_value), .low_value(low_value),
    .pc_high_latch(pc_high_latch));

  // ==========================================================
  // Checking and bus tasks
  task automatic stop_test;
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [13:0] ad(input logic [11:0] i);
    return {i, 2'h0};
  endfunction

  task automatic axi_wr(input logic [11:0] i, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr <= ad(i);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (pa && awready) begin pa = 1'b0; awvalid <= 1'b0; end
      if (pw && wready) begin pw = 1'b0; wvalid <= 1'b0; end
    end while (pa || pw);
    do @(posedge aclk); while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [13:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] i, input logic [31:0] e);
    axi_rd(ad(i));
    chk(rd, e);
  endtask

  // ==========================================================
  // Step model
  function automatic logic [14:0] nxt(input step_op_e o,
      input logic [10:0] t, input logic [8:0] b, input logic [7:0] w,
      input logic [7:0] p, input logic [6:0] l);
    case (o)
      OP_LOW_WRITE:   return {l, p};
      OP_CALL:        return {l[6:3], t};
      OP_CALL_WORK:   return {l, w};
      OP_BRANCH_WORK: return m_pc + 15'h1 + {7'h00, w};
      OP_BRANCH_REL:  return m_pc + 15'h1 + {{6{b[8]}}, b};
      OP_IRQ:         return IRQ_VECTOR_DEF;
      default:        return m_pc + 15'h1;
    endcase
  endfunction

  task automatic stp(input step_op_e o);
    logic [31:0] x;
    logic [31:0] y;
    logic [14:0] d;
    logic flt;
    x = $random(seed);
    y = $random(seed);
    core.run(o, x[10:0], x[19:11], x[27:20], y[15:8], y[6:0]);
    #1;
    d = (o == OP_IRQ) ? m_pc : m_pc + 15'h1;
    flt = 1'b0;
    if (o inside {OP_CALL, OP_CALL_WORK, OP_IRQ}) begin
      if (m_lvl >= 5'h0f && m_lvl != 5'h1f) begin
        m_flg[0] = 1'b1;
        flt = fre;
      end
      if (!flt) begin
        m_lvl++;
        m_stk[m_lvl[3:0]] = d;
      end
    end
    if (o == OP_RETURN && m_lvl == 5'h1f) begin
      m_flg[1] = 1'b1;
      flt = fre;
    end
    if (flt) begin
      m_pc = 15'h0000;
      m_lvl = 5'h1f;
    end else if (o == OP_RETURN) begin
      m_pc = m_stk[m_lvl[3:0]];
      m_lvl--;
    end else m_pc = nxt(o, x[10:0], x[19:11], x[27:20], y[15:8], y[6:0]);
    chk(pc, m_pc);
    chk(fault, flt);
    rchk(IDX_LEVEL, m_lvl);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(pc, 15'h0000);
    rchk(IDX_LEVEL, 32'h1f);
    repeat (17) stp(OP_CALL);
    rchk(IDX_STATUS, 32'h1);
    repeat (60) begin
      r = $random(seed);
      stp(step_op_e'(r[2:0]));
    end
    rchk(IDX_STATUS, m_flg);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    m_pc = 15'h0000;
    m_lvl = 5'h1f;
    m_flg = 2'h0;
    #1;
    chk(pc, m_pc);
    rchk(IDX_LEVEL, 32'h1f);
    rchk(IDX_STATUS, 32'h0);
    ce <= 1'b0;
    core.run(OP_BRANCH_WORK, 11'h000, 9'h000, 8'h40, 8'h00, 7'h00);
    #1;
    chk(pc, m_pc);
    @(posedge aclk);
    ce <= 1'b1;
    axi_wr(IDX_LEVEL, 32'h3);
    chk(bs, RESP_OKAY);
    axi_wr(IDX_TOS_LOW, 32'h5a);
    axi_wr(IDX_TOS_HIGH, 32'h21);
    m_lvl = 5'h03;
    m_stk[3] = 15'h215a;
    rchk(IDX_TOS_LOW, 32'h5a);
    rchk(IDX_TOS_HIGH, 32'h21);
    stp(OP_RETURN);
    axi_rd(14'h0000);
    chk(rs, RESP_SLVERR);
    axi_wr(12'h000, 32'h0);
    chk(bs, RESP_SLVERR);
    axi_wr(IDX_CLEAR, 32'h3);
    axi_wr(IDX_ENABLE, 32'h3);
    rchk(IDX_STATUS, 32'h0);
    chk(irq, 1'b0);
    strb <= 4'h0;
    axi_wr(IDX_ENABLE, 32'h0);
    strb <= 4'hf;
    rchk(IDX_ENABLE, 32'h3);
    fre <= 1'b1;
    axi_wr(IDX_LEVEL, 32'hf);
    m_lvl = 5'h0f;
    m_flg = 2'h0;
    stp(OP_CALL);
    chk(irq, 1'b1);
    stp(OP_RETURN);
    rchk(IDX_STATUS, 32'h3);
    axi_wr(IDX_CLEAR, 32'h1);
    rchk(IDX_STATUS, 32'h2);
    axi_wr(IDX_ENABLE, 32'h1);
    @(posedge aclk);
    #1;
    chk(irq, 1'b0);
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    stop_test;
  end
endmodule // pc_stack_top_test
